// >>> bench/fpe_flash_ctl_tb.sv
// self-checking bench for the flash program/erase controller
`timescale 1ns/10ps
`default_nettype none
module fpe_flash_ctl_tb;
    import fpe_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    logic        mclk         = 1'b0;
    logic        reset        = 1'b1;
    fpe_bus_s    bus          = '0;
    logic [7:0]  rd_data;
    logic        read_stretch;
    logic        hv_drive;
    logic        pump_tick;
    int          n_errors     = 0;
    int          checks_done  = 0;
    int          cyc          = 0;
    int          tick_cnt     = 0;
    int          str_cnt      = 0;
    int          t0;
    logic [15:0] ta [4]       = '{16'h7800, 16'h7808, 16'h7840, 16'h7C00};

    // short waits keep the full-array erase within a few thousand cycles
    fpe_flash_ctl #(
        .ERASE_CYCLES     (16'h0004),
        .DISCHARGE_CYCLES (16'h0004),
        .RECOVERY_CYCLES  (16'h0004)
    ) dut_u (
        .mclk         (mclk),
        .reset        (reset),
        .bus          (bus),
        .rd_data      (rd_data),
        .read_stretch (read_stretch),
        .hv_drive     (hv_drive),
        .pump_tick    (pump_tick)
    );

    // 20 MHz bus clock keeps every operation above the 2 MHz floor
    always #25 mclk = ~mclk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report();
        $display("checks %0d, errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // pulse counters and hang guard
    always @(posedge mclk) begin
        cyc++;
        if (pump_tick === 1'b1) tick_cnt++;
        if (read_stretch === 1'b1) str_cnt++;
        if (cyc == 40000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask

    // data stand from the cycle after the strobe until the next read
    task automatic rd_raw(input logic [15:0] a);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus.rd <= 1'b0;
        @(negedge mclk);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        rd_raw(a);
        chk({8'h00, rd_data}, {8'h00, e});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic prog(input logic [15:0] a, input logic [7:0] d);
        wr(FPE_CTRL_ADDR, 8'h01);
        rd(FPE_PROT_ADDR, 8'h00);
        wr(a, d);
        wr(FPE_CTRL_ADDR, 8'h09);
        @(negedge mclk);
        chk({15'h0000, hv_drive}, 16'h0001);
        wr(FPE_CTRL_ADDR, 8'h0D);
        rd(FPE_CTRL_ADDR, 8'h09);
        wr(FPE_CTRL_ADDR, 8'h01);
        wr(FPE_CTRL_ADDR, 8'h00);
        rd(a, 8'h00);
        repeat (10) @(posedge mclk);
        rd(a, d);
    endtask

    task automatic er(input logic [15:0] a, input fpe_size_e sz, input logic h);
        logic [7:0] c;
        c = {1'b0, h, sz, 4'h2};
        wr(FPE_CTRL_ADDR, c);
        rd(FPE_CTRL_ADDR, c);
        rd(16'h0080, 8'h00);
        rd(FPE_PROT_ADDR, 8'h00);
        wr(a, 8'h5A);
        wr(16'h0090, 8'h33);
        wr(FPE_CTRL_ADDR, c | 8'h08);
        @(negedge mclk);
        chk({15'h0000, hv_drive}, 16'h0001);
        repeat (2) @(negedge mclk);
        t0 = tick_cnt;
        repeat (8) @(negedge mclk);
        chk(16'(tick_cnt - t0), h ? 16'h0004 : 16'h0008);
        repeat (4200) @(posedge mclk);
        wr(FPE_CTRL_ADDR, c);
        repeat (6) @(posedge mclk);
        wr(FPE_CTRL_ADDR, c & 8'h70);
        repeat (10) @(posedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        rd(FPE_CTRL_ADDR, FPE_CTRL_RESET);
        rd(16'h0080, 8'h00);
        wr(FPE_CTRL_ADDR, 8'h01);
        wr(FPE_CTRL_ADDR, 8'h03);
        rd(FPE_CTRL_ADDR, 8'h01);
        wr(FPE_CTRL_ADDR, 8'h00);
        wr(FPE_CTRL_ADDR, 8'h03);
        // busy bit still set: recovery from the cleared select is counting
        rd(FPE_CTRL_ADDR, 8'h80);
        wr(FPE_CTRL_ADDR, 8'h02);
        wr(FPE_CTRL_ADDR, 8'h0A);
        rd(FPE_CTRL_ADDR, 8'h02);
        @(negedge mclk);
        chk({15'h0000, hv_drive}, 16'h0000);
        wr(FPE_CTRL_ADDR, 8'h00);
        repeat (10) @(posedge mclk);
        // a program aimed at the protection byte is cancelled
        wr(FPE_CTRL_ADDR, 8'h01);
        rd(FPE_PROT_ADDR, 8'h00);
        wr(FPE_PROT_ADDR, 8'h5A);
        rd(FPE_CTRL_ADDR, 8'h80);
        wr(FPE_CTRL_ADDR, 8'h09);
        @(negedge mclk);
        chk({15'h0000, hv_drive}, 16'h0000);
        wr(FPE_CTRL_ADDR, 8'h00);
        repeat (10) @(posedge mclk);
        prog(16'h7808, 8'hA5);
        prog(16'h7810, 8'h3C);
        // margin read of the array holds the stretch flag for eight cycles
        t0 = str_cnt;
        wr(FPE_CTRL_ADDR, 8'h04);
        rd(16'h7808, 8'hA5);
        repeat (12) @(negedge mclk);
        chk(16'(str_cnt - t0), 16'h0008);
        wr(FPE_CTRL_ADDR, 8'h00);
        repeat (10) @(posedge mclk);
        er(16'h780C, FPE_SZ_ROW, 1'b1);
        rd(16'h7808, FPE_ERASED);
        rd(16'h7810, 8'h3C);
        // every block size, erase address at the base of the array
        for (int s = 0; s < 4; s++) begin
            for (int i = 0; i < 4; i++) prog(ta[i], 8'h11 << i);
            er(16'h7800, fpe_size_e'(s), s == 3);
            for (int i = 0; i < 4; i++) begin
                rd(ta[i], (s != 0 && i >= 4 - s) ? 8'h11 << i : 8'h00);
            end
        end
        final_report();
    end

endmodule
`default_nettype wire

// >>> hdl/fpe_flash_ctl.sv
// flash program/erase sequencer with control register and pump divider
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module fpe_flash_ctl #(
    parameter logic [15:0] ERASE_CYCLES    = fpe_pkg::FPE_ERASE_DEF,
    parameter logic [15:0] DISCHARGE_CYCLES = fpe_pkg::FPE_DISCH_DEF,
    parameter logic [15:0] RECOVERY_CYCLES  = fpe_pkg::FPE_RECOV_DEF
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // cpu bus
    input  wire fpe_pkg::fpe_bus_s bus,
    output logic      [7:0]       rd_data,
    output logic                  read_stretch,
    // charge pump
    output logic                  hv_drive,
    output logic                  pump_tick
);
    import fpe_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    fpe_ctrl_s  ctrl_q;
    fpe_ctrl_s  wr_ctrl;
    fpe_state_e state_q;
    logic [3:0]  prot_q;
    logic [15:0] lat_addr_q;
    logic [7:0]  lat_data_q;
    logic [10:0] walk_idx_q;
    logic [11:0] walk_left_q;
    logic [15:0] erase_cnt_q;
    logic [15:0] disch_cnt_q;
    logic [15:0] recov_cnt_q;
    logic [3:0]  stretch_cnt_q;
    logic        prog_pend_q;
    logic        phase_q;
    logic [7:0]  nv_byte;
    logic        ctrl_wr;
    logic        prot_rd;
    logic        array_rd;
    logic        array_wr;
    logic        pgm_n;
    logic        era_n;
    logic        hv_n;
    logic        mar_n;
    logic        latch_ev;
    logic        cancel;
    logic        hv_enter;
    logic        readable;
    logic        busy;
    logic        erase_step;
    logic [10:0] size_mask;

    assign ctrl_wr  = bus.wr && (bus.addr == FPE_CTRL_ADDR);
    assign prot_rd  = bus.rd && (bus.addr == FPE_PROT_ADDR);
    assign array_rd = bus.rd && fpe_is_array(bus.addr);
    assign array_wr = bus.wr && fpe_is_array(bus.addr);
    assign wr_ctrl  = fpe_ctrl_s'(bus.wdata);
    assign size_mask = fpe_erase_mask(fpe_size_e'({ctrl_q.erase_size_hi, ctrl_q.erase_size_lo}));

    // a request for both selects keeps whichever is already set
    assign pgm_n = wr_ctrl.program_select & (~wr_ctrl.erase_select | ctrl_q.program_select);
    assign era_n = wr_ctrl.erase_select & (~wr_ctrl.program_select | ctrl_q.erase_select);
    assign hv_n  = wr_ctrl.high_voltage_on & (pgm_n | era_n)
                 & ((state_q == FPE_ST_LATCHED) || (state_q == FPE_ST_HIGHV));
    assign mar_n = wr_ctrl.margin_select & ~hv_n & ~ctrl_q.high_voltage_on;

    assign hv_enter = ctrl_wr && hv_n && (state_q == FPE_ST_LATCHED);
    assign latch_ev = array_wr && (state_q == FPE_ST_PROTREAD);
    assign busy     = (disch_cnt_q != 16'h0000) || (recov_cnt_q != 16'h0000);
    assign readable = (state_q == FPE_ST_IDLE) && (recov_cnt_q == 16'h0000);

    ////////////////////////////////////////////////////////////////////////////
    // protection check on the latched target

    function automatic logic prot_hit(input logic [15:0] a, input logic ers,
                                      input logic [10:0] msk, input logic [3:0] p);
        logic [15:0] first;
        logic [15:0] last;
        first = p[0] ? FPE_PROT_START0 : p[1] ? FPE_PROT_START1 :
                p[2] ? FPE_PROT_START2 : FPE_PROT_START3;
        last  = ers ? {5'b01111, a[10:0] | ~msk} : a;
        if (a == FPE_PROT_ADDR || (ers && a[15])) begin
            return 1'b1;
        end
        if (p == 4'h0) begin
            return 1'b0;
        end
        return a[15] || (last >= first);
    endfunction

    assign cancel = latch_ev && prot_hit(bus.addr, ctrl_q.erase_select, size_mask, prot_q);

    ////////////////////////////////////////////////////////////////////////////
    // control register

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ctrl_q <= fpe_ctrl_s'(FPE_CTRL_RESET);
        end else if (ctrl_wr) begin
            ctrl_q.pump_clock_halve <= wr_ctrl.pump_clock_halve;
            ctrl_q.erase_size_hi    <= wr_ctrl.erase_size_hi;
            ctrl_q.erase_size_lo    <= wr_ctrl.erase_size_lo;
            ctrl_q.high_voltage_on  <= hv_n;
            ctrl_q.margin_select    <= mar_n;
            ctrl_q.erase_select     <= era_n;
            ctrl_q.program_select   <= pgm_n;
        end else if (cancel) begin
            ctrl_q.erase_select   <= 1'b0;
            ctrl_q.program_select <= 1'b0;
        end
    end

    assign hv_drive = ctrl_q.high_voltage_on;

    ////////////////////////////////////////////////////////////////////////////
    // sequence tracking

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_q <= FPE_ST_IDLE;
        end else if (ctrl_wr && (state_q != FPE_ST_IDLE) && !(pgm_n || era_n)) begin
            state_q <= FPE_ST_IDLE;
        end else begin
            unique case (state_q)
                FPE_ST_IDLE: begin
                    if (ctrl_wr && (pgm_n || era_n)) begin
                        state_q <= FPE_ST_SELECTED;
                    end
                end
                FPE_ST_SELECTED: begin
                    if (prot_rd) begin
                        state_q <= FPE_ST_PROTREAD;
                    end
                end
                FPE_ST_PROTREAD: begin
                    if (latch_ev) begin
                        state_q <= cancel ? FPE_ST_IDLE : FPE_ST_LATCHED;
                    end
                end
                FPE_ST_LATCHED: begin
                    if (hv_enter) begin
                        state_q <= FPE_ST_HIGHV;
                    end
                end
                FPE_ST_HIGHV: begin
                    if (ctrl_wr && !hv_n) begin
                        state_q <= FPE_ST_LATCHED;
                    end
                end
                default: begin
                    state_q <= FPE_ST_IDLE;
                end
            endcase
        end
    end

    // low four bits of the protection byte captured on every read of it
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prot_q <= 4'h0;
        end else if (prot_rd) begin
            prot_q <= nv_byte[3:0];
        end
    end

    // target address and data
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lat_addr_q <= FPE_USER_BASE;
            lat_data_q <= FPE_ERASED;
        end else if (latch_ev) begin
            lat_addr_q <= bus.addr;
            lat_data_q <= bus.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pump clock divider

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            phase_q   <= 1'b0;
            pump_tick <= 1'b0;
        end else begin
            phase_q   <= ctrl_q.high_voltage_on ? ~phase_q : 1'b0;
            pump_tick <= ctrl_q.high_voltage_on & (~ctrl_q.pump_clock_halve | phase_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // high-voltage actions: one byte program or a paced block erase

    assign erase_step = (state_q == FPE_ST_HIGHV) && ctrl_q.erase_select
                      && (erase_cnt_q == 16'h0000) && (walk_left_q != 12'h000) && pump_tick;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            prog_pend_q <= 1'b0;
            erase_cnt_q <= 16'h0000;
            walk_idx_q  <= 11'h000;
            walk_left_q <= 12'h000;
        end else if (hv_enter) begin
            prog_pend_q <= pgm_n;
            erase_cnt_q <= ERASE_CYCLES;
            walk_idx_q  <= lat_addr_q[10:0] & size_mask;
            walk_left_q <= era_n ? ({1'b0, ~size_mask} + 12'h001) : 12'h000;
        end else begin
            prog_pend_q <= 1'b0;
            if ((state_q == FPE_ST_HIGHV) && (erase_cnt_q != 16'h0000)) begin
                erase_cnt_q <= erase_cnt_q - 16'h0001;
            end
            if (erase_step) begin
                walk_idx_q  <= walk_idx_q + 11'h001;
                walk_left_q <= walk_left_q - 12'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // discharge and recovery waits

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            disch_cnt_q <= 16'h0000;
            recov_cnt_q <= 16'h0000;
        end else begin
            if (ctrl_q.high_voltage_on && ctrl_wr && !hv_n) begin
                disch_cnt_q <= DISCHARGE_CYCLES;
            end else if (disch_cnt_q != 16'h0000) begin
                disch_cnt_q <= disch_cnt_q - 16'h0001;
            end
            if ((state_q != FPE_ST_IDLE) && ctrl_wr && !(pgm_n || era_n)) begin
                recov_cnt_q <= RECOVERY_CYCLES;
            end else if (cancel) begin
                recov_cnt_q <= RECOVERY_CYCLES;
            end else if (recov_cnt_q != 16'h0000) begin
                recov_cnt_q <= recov_cnt_q - 16'h0001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data and margin stretch

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            rd_data <= FPE_READ_ZERO;
        end else if (bus.rd) begin
            if (bus.addr == FPE_CTRL_ADDR) begin
                rd_data <= {busy, ctrl_q[6:0]};
            end else if (prot_rd || (array_rd && readable)) begin
                rd_data <= nv_byte;
            end else begin
                rd_data <= FPE_READ_ZERO;
            end
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            stretch_cnt_q <= 4'h0;
            read_stretch  <= 1'b0;
        end else if (array_rd && ctrl_q.margin_select) begin
            stretch_cnt_q <= FPE_STRETCH_CYC;
            read_stretch  <= 1'b1;
        end else begin
            if (stretch_cnt_q != 4'h0) begin
                stretch_cnt_q <= stretch_cnt_q - 4'h1;
            end
            read_stretch <= stretch_cnt_q > 4'h1;
        end
    end

    fpe_nv_array u_array (
        .mclk      (mclk),
        .rd_idx    (fpe_index(bus.addr)),
        .rd_byte   (nv_byte),
        .prog_en   (prog_pend_q && (state_q == FPE_ST_HIGHV)),
        .erase_en  (erase_step),
        .wr_idx    (prog_pend_q ? fpe_index(lat_addr_q) : {1'b0, walk_idx_q}),
        .prog_byte (lat_data_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks

    sequence s_margin_read;
        array_rd && ctrl_q.margin_select;
    endsequence

    sequence s_latch_cancel;
        latch_ev && cancel;
    endsequence

    a_select_interlock: assert property (@(posedge mclk) disable iff (reset)
        !(ctrl_q.program_select && ctrl_q.erase_select))
        else $error("program and erase selected together");

    a_margin_hv_lock: assert property (@(posedge mclk) disable iff (reset)
        ctrl_q.high_voltage_on |-> !ctrl_q.margin_select)
        else $error("margin select set with high voltage");

    a_hv_needs_seq: assert property (@(posedge mclk) disable iff (reset)
        $rose(ctrl_q.high_voltage_on) |-> $past(state_q) == FPE_ST_LATCHED
            && (ctrl_q.program_select || ctrl_q.erase_select))
        else $error("high voltage set out of sequence");

    a_pump_full_rate: assert property (@(posedge mclk) disable iff (reset)
        (ctrl_q.high_voltage_on && !ctrl_q.pump_clock_halve) |=> pump_tick)
        else $error("undivided pump tick missing");

    a_pump_half_rate: assert property (@(posedge mclk) disable iff (reset)
        (pump_tick && ctrl_q.pump_clock_halve && $past(ctrl_q.pump_clock_halve)) |=> !pump_tick)
        else $error("halved pump ticks back to back");

    a_margin_stretch: assert property (@(posedge mclk) disable iff (reset)
        s_margin_read |=> read_stretch [*8])
        else $error("margin read stretch shorter than eight");

    a_read_blocked: assert property (@(posedge mclk) disable iff (reset)
        (array_rd && !prot_rd && !readable) |=> rd_data == FPE_READ_ZERO)
        else $error("array read before recovery");

    a_protect_cancel: assert property (@(posedge mclk) disable iff (reset)
        s_latch_cancel |=> (state_q == FPE_ST_IDLE) && !ctrl_q.program_select
            && !ctrl_q.erase_select ##1 !ctrl_q.high_voltage_on)
        else $error("protected target kept its select");

    a_latch_addr: assert property (@(posedge mclk) disable iff (reset)
        latch_ev |=> lat_addr_q == $past(bus.addr) && lat_data_q == $past(bus.wdata))
        else $error("target address not latched");

    a_ctrl_readback: assert property (@(posedge mclk) disable iff (reset)
        (bus.rd && bus.addr == FPE_CTRL_ADDR) |=> rd_data[6:0] == $past(ctrl_q[6:0]))
        else $error("control read mismatch");

endmodule
`default_nettype wire

// >>> hdl/fpe_nv_array.sv
// nonvolatile byte store: program ors bits in, erase clears a byte
`timescale 1ns/10ps
`default_nettype none
module fpe_nv_array (
    // clock
    input  wire logic        mclk,
    // read port
    input  wire logic [11:0] rd_idx,
    output logic      [7:0]  rd_byte,
    // program / erase port
    input  wire logic        prog_en,
    input  wire logic        erase_en,
    input  wire logic [11:0] wr_idx,
    input  wire logic [7:0]  prog_byte
);
    import fpe_pkg::*;

    logic [7:0] cells [FPE_NV_DEPTH];

    // parts leave the factory erased
    initial begin
        for (int i = 0; i < FPE_NV_DEPTH; i++) begin
            cells[i] = FPE_ERASED;
        end
    end

    always_ff @(posedge mclk) begin
        if (erase_en) begin
            cells[wr_idx] <= FPE_ERASED;
        end else if (prog_en) begin
            cells[wr_idx] <= cells[wr_idx] | prog_byte;
        end
    end

    assign rd_byte = cells[rd_idx];

endmodule
`default_nettype wire

// >>> hdl/fpe_pkg.sv
// constants, types and helpers for the flash program/erase controller
//
// What this block does
// - erased bit reads 0, programmed bit 1
// - user space 7800, protect FFF0, control FE08
// - rows of eight one-byte pages
// - program one byte; erase at least one row
// - pump clock is bus clock divided 1 or 2
// - high voltage only after selected, proper sequence
// - margin select refused while high voltage on
// - erase and program select never both set
// - size bits pick 2K, 1K, 64 or 8
// - array write latches block address for erase
// - unrelated bus traffic between steps tolerated
// - array readable only after recovery wait
// - protect read latches; protected target cancels select
// - margin read stretched by eight bus cycles
package fpe_pkg;

    // bus map
    localparam logic [15:0] FPE_CTRL_ADDR  = 16'hFE08;
    localparam logic [15:0] FPE_PROT_ADDR  = 16'hFFF0;
    localparam logic [15:0] FPE_USER_BASE  = 16'h7800;
    localparam logic [15:0] FPE_USER_LAST  = 16'h7FFF;
    localparam logic [15:0] FPE_HIGH_BASE  = 16'hFFF0;

    // start of each protected range, one per protection bit
    localparam logic [15:0] FPE_PROT_START0 = 16'h7800;
    localparam logic [15:0] FPE_PROT_START1 = 16'h7880;
    localparam logic [15:0] FPE_PROT_START2 = 16'h7900;
    localparam logic [15:0] FPE_PROT_START3 = 16'h7A00;

    // array geometry: 2048 main bytes plus a 16-byte high page
    localparam int          FPE_MAIN_DEPTH = 2048;
    localparam int          FPE_NV_DEPTH   = 2064;
    localparam logic [7:0]  FPE_ERASED     = 8'h00;
    localparam logic [7:0]  FPE_CTRL_RESET = 8'h00;
    localparam logic [7:0]  FPE_READ_ZERO  = 8'h00;

    // cared address bits per erase size
    localparam logic [10:0] FPE_MASK_FULL  = 11'h000;
    localparam logic [10:0] FPE_MASK_HALF  = 11'h400;
    localparam logic [10:0] FPE_MASK_ROWS8 = 11'h7C0;
    localparam logic [10:0] FPE_MASK_ROW   = 11'h7F8;

    // timing
    localparam logic [3:0]  FPE_STRETCH_CYC  = 4'h8;
    localparam logic [15:0] FPE_ERASE_DEF    = 16'h0100;
    localparam logic [15:0] FPE_DISCH_DEF    = 16'h0010;
    localparam logic [15:0] FPE_RECOV_DEF    = 16'h0010;

    typedef enum logic [1:0] {
        FPE_SZ_FULL  = 2'h0,
        FPE_SZ_HALF  = 2'h1,
        FPE_SZ_ROWS8 = 2'h2,
        FPE_SZ_ROW   = 2'h3
    } fpe_size_e;

    typedef enum logic [4:0] {
        FPE_ST_IDLE     = 5'h01,
        FPE_ST_SELECTED = 5'h02,
        FPE_ST_PROTREAD = 5'h04,
        FPE_ST_LATCHED  = 5'h08,
        FPE_ST_HIGHV    = 5'h10
    } fpe_state_e;

    // flash_control layout, bit 7 down to bit 0
    typedef struct packed {
        logic busy;
        logic pump_clock_halve;
        logic erase_size_hi;
        logic erase_size_lo;
        logic high_voltage_on;
        logic margin_select;
        logic erase_select;
        logic program_select;
    } fpe_ctrl_s;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } fpe_bus_s;

    function automatic logic fpe_is_array(input logic [15:0] a);
        return ((a >= FPE_USER_BASE) && (a <= FPE_USER_LAST)) || (a >= FPE_HIGH_BASE);
    endfunction

    // main bytes map to 0..2047, the high page to 2048..2063
    function automatic logic [11:0] fpe_index(input logic [15:0] a);
        return a[15] ? {8'h80, a[3:0]} : {1'b0, a[10:0]};
    endfunction

    function automatic logic [10:0] fpe_erase_mask(input fpe_size_e sz);
        unique case (sz)
            FPE_SZ_FULL:  return FPE_MASK_FULL;
            FPE_SZ_HALF:  return FPE_MASK_HALF;
            FPE_SZ_ROWS8: return FPE_MASK_ROWS8;
            FPE_SZ_ROW:   return FPE_MASK_ROW;
        endcase
    endfunction

endpackage
